// *** src/rmd_pkg.sv ***
// Purpose: Shared constants and types for the RS-485 multidrop block
// Assumes: 100 MHz clock, APB register access, 32-bit data words
// Notes: Offsets are byte addresses on the APB bus
package rmd_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 115_200;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int FRAME_BITS = 9;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_EFC = 8'h00;
  localparam logic [7:0] OFF_EFR = 8'h04;
  localparam logic [7:0] OFF_LFC = 8'h08;
  localparam logic [7:0] OFF_IER = 8'h0C;
  localparam logic [7:0] OFF_XC2 = 8'h10;
  localparam logic [7:0] OFF_TXD = 8'h14;
  localparam logic [7:0] OFF_RXD = 8'h18;
  localparam logic [7:0] OFF_LST = 8'h1C;
  localparam logic [7:0] OFF_IST = 8'h20;
  localparam logic [7:0] OFF_IMK = 8'h24;
  localparam logic [7:0] OFF_RTM = 8'h28;

  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int EFC_MDROP = 0;
  localparam int EFC_RXDIS = 1;
  localparam int EFC_TRANSMITTER_RTS_CONTROL = 4;
  localparam int EFC_RTSINV = 5;
  localparam logic [7:0] EFC_MASK = 8'h33;
  localparam int EFR_SDET = 5;
  localparam int IER_LSI = 2;
  localparam int LST_DR = 0;
  localparam int LST_OVR = 1;
  localparam int LST_PERR = 2;
  localparam int IST_RX = 0;
  localparam int IST_LS = 1;
  localparam int IST_TX = 2;
  localparam logic [2:0] PAR_FORCE0 = 3'h7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] EFC_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] IST_RST = 3'h0;

  // ----------------------------------------
  // Serial shifter states
  // ----------------------------------------
  typedef enum logic [1:0] {
    RMD_IDLE = 2'b00,
    RMD_START = 2'b01,
    RMD_DATA = 2'b10,
    RMD_STOP = 2'b11
  } rmd_state_t;
endpackage

// *** src/rmd_rx.sv ***
// Purpose: Serial receiver for start, eight data bits, parity bit, stop
// Assumes: i_rxd already synchronised to i_clk
// Notes: A frame with a low stop bit is dropped
module rmd_rx #(
  parameter int BIT_CYC = rmd_pkg::BIT_CYC,
  parameter int NBITS = rmd_pkg::FRAME_BITS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rxd,
  output logic o_valid,
  output logic [NBITS-1:0] o_data
);
  localparam int CW = $clog2(BIT_CYC);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);
  localparam logic [3:0] LAST = 4'(NBITS - 1);

  rmd_pkg::rmd_state_t st;
  logic [CW-1:0] cnt;
  logic [3:0] idx;
  logic [NBITS-1:0] sh;
  wire tick = (cnt == '0);

  // ----------------------------------------
  // Frame sampler, mid-bit
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st <= rmd_pkg::RMD_IDLE;
      cnt <= '0;
      idx <= 4'h0;
      sh <= '0;
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      o_valid <= 1'b0;
      if (!tick) cnt <= cnt - 1'b1;
      unique case (st)
        rmd_pkg::RMD_IDLE: begin
          if (!i_rxd) begin
            st <= rmd_pkg::RMD_START;
            cnt <= HALF;
          end
        end
        rmd_pkg::RMD_START: begin
          if (tick) begin
            st <= i_rxd ? rmd_pkg::RMD_IDLE : rmd_pkg::RMD_DATA;
            cnt <= FULL;
            idx <= 4'h0;
          end
        end
        rmd_pkg::RMD_DATA: begin
          if (tick) begin
            sh <= {i_rxd, sh[NBITS-1:1]};
            cnt <= FULL;
            idx <= idx + 4'h1;
            if (idx == LAST) st <= rmd_pkg::RMD_STOP;
          end
        end
        rmd_pkg::RMD_STOP: begin
          if (tick) begin
            st <= rmd_pkg::RMD_IDLE;
            o_valid <= i_rxd;
            if (i_rxd) o_data <= sh;
          end
        end
      endcase
    end
  end

  rx_pulse_one_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_valid |=> !o_valid) else $error("rx valid longer than one cycle");
endmodule

// *** src/rmd_top.sv ***
// Purpose: RS-485 multidrop receive filter and automatic RTS direction control
// Assumes: APB master on I_CLK; I_RXD asynchronous serial line
// Notes on behaviour
// [RULE_01] With RTS control on and inversion set, RTS is high while sending and low after.
// [RULE_02] Multidrop receive runs only while the multidrop enable bit is set.
// [RULE_03] In multidrop a parity bit of 1 marks an address, 0 marks data.
// [RULE_04] Software turns flow control off before using RS-485 operation.
// [RULE_05] Software keeps special detect off and forces parity 0 for normal multidrop.
// [RULE_06] Normal multidrop with receiver off drops data and stores addresses with parity error.
// [RULE_07] An address in normal multidrop raises a line status interrupt if enabled.
// [RULE_08] Software enables the receiver only for its own station address.
// [RULE_09] An enabled receiver takes every character; a new address flags parity error again.
// [RULE_10] With special detect on, addresses are compared to the programmed address byte.
// [RULE_11] Auto detection drops data and foreign addresses while the receiver is off.
// [RULE_12] A matching address enables the receiver and is stored with its parity bit.
// [RULE_13] A matching address raises a line status interrupt if enabled.
// [RULE_14] A foreign address while enabled disables the receiver and is dropped.
// [RULE_15] RTS control drives RTS low from a transmit write until the last bit is out.
// [RULE_16] The receiver disable bit stops reception at once; clearing it resumes it.
// [RULE_17] The compare uses all eight data bits and acts on the software enable bit.
module rmd_top #(
  parameter int BIT_CYC = rmd_pkg::BIT_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_RXD,
  output logic O_TXD,
  output logic O_RTS_N,
  output logic O_IRQ
);
  logic [7:0] efc, enhanced_features_reg, lfc, interrupt_enable_reg, xc2, rtm;
  logic [2:0] ist, imk;
  logic [7:0] rx_data;
  logic rx_dr, rx_ovr, rx_perr;
  logic [8:0] tx_hold;
  logic tx_hold_v, tx_busy, tx_busy_q;
  logic rxd_s1, rxd_s2;
  logic rx_v;
  logic [8:0] rx_word;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // A transfer counts only at the ready edge; the setup and wait cycles
  // have no side effects, but a request held past ready is taken again two cycles later
  wire acc = I_PSEL & I_PENABLE;
  wire wr = acc & I_PWRITE & O_PREADY;
  wire rd = acc & ~I_PWRITE & O_PREADY;
  wire hit_efc = I_PADDR == rmd_pkg::OFF_EFC;
  wire hit_efr = I_PADDR == rmd_pkg::OFF_EFR;
  wire hit_lfc = I_PADDR == rmd_pkg::OFF_LFC;
  wire hit_ier = I_PADDR == rmd_pkg::OFF_IER;
  wire hit_xc2 = I_PADDR == rmd_pkg::OFF_XC2;
  wire hit_txd = I_PADDR == rmd_pkg::OFF_TXD;
  wire hit_rxd = I_PADDR == rmd_pkg::OFF_RXD;
  wire hit_lst = I_PADDR == rmd_pkg::OFF_LST;
  wire hit_ist = I_PADDR == rmd_pkg::OFF_IST;
  wire hit_imk = I_PADDR == rmd_pkg::OFF_IMK;
  wire hit_rtm = I_PADDR == rmd_pkg::OFF_RTM;
  // Unmapped offsets answer with an error and read as zero
  wire mapped = hit_efc | hit_efr | hit_lfc | hit_ier | hit_xc2 | hit_txd | hit_rxd
    | hit_lst | hit_ist | hit_imk | hit_rtm;
  wire [7:0] lst = {5'h00, rx_perr, rx_ovr, rx_dr};
  // Read select; unused upper bits always read zero
  wire [31:0] rdata =
    hit_efc ? {24'h000000, efc} :
    hit_efr ? {24'h000000, enhanced_features_reg} :
    hit_lfc ? {24'h000000, lfc} :
    hit_ier ? {24'h000000, interrupt_enable_reg} :
    hit_xc2 ? {24'h000000, xc2} :
    hit_txd ? {22'h000000, tx_hold_v | tx_busy, tx_hold} :
    hit_rxd ? {24'h000000, rx_data} :
    hit_lst ? {24'h000000, lst} :
    hit_ist ? {29'h00000000, ist} :
    hit_imk ? {29'h00000000, imk} :
    hit_rtm ? {24'h000000, rtm} : 32'h00000000;

  // Access phase answered one cycle after it opens
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h00000000;
    end else begin
      O_PREADY <= acc & ~O_PREADY;
      O_PSLVERR <= acc & ~O_PREADY & ~mapped;
      if (acc & ~O_PREADY & ~I_PWRITE) O_PRDATA <= rdata;
    end
  end

  // ----------------------------------------
  // Receive line and shifters
  // ----------------------------------------
  // Two-stage synchroniser on the line; only the second stage is read,
  // so a metastable first stage never reaches the frame sampler
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      rxd_s1 <= I_RXD;
      rxd_s2 <= rxd_s1;
    end
  end

  // Receiver sees the line two cycles late; this only moves the store
  // point, the mid-bit sampling itself is unaffected
  rmd_rx #(.BIT_CYC(BIT_CYC), .NBITS(rmd_pkg::FRAME_BITS)) u_rx (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_rxd(rxd_s2),
    .o_valid(rx_v),
    .o_data(rx_word)
  );

  // Holding register feeds the shifter as soon as the shifter is idle
  wire tx_start = tx_hold_v & ~tx_busy;

  rmd_tx #(.BIT_CYC(BIT_CYC), .NBITS(rmd_pkg::FRAME_BITS)) u_tx (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_start(tx_start),
    .i_data(tx_hold),
    .o_txd(O_TXD),
    .o_busy(tx_busy)
  );

  // ----------------------------------------
  // Character classification
  // ----------------------------------------
  // [RULE_02] [RULE_03] mode and address bit
  wire md = efc[rmd_pkg::EFC_MDROP];
  wire sdet = enhanced_features_reg[rmd_pkg::EFR_SDET];
  wire rx_on = ~efc[rmd_pkg::EFC_RXDIS];
  wire is_addr = rx_word[8];
  // [RULE_10] [RULE_17] full byte compare
  wire match = rx_word[7:0] == xc2;
  // Normal mode obeys the enable bit alone; multidrop without detect
  // always keeps addresses; auto detect keeps only the matching one,
  // and data follow the enable bit in every mode
  // [RULE_06] [RULE_09] [RULE_11] [RULE_16] store filter
  wire keep = ~md ? rx_on : ~sdet ? (is_addr | rx_on) : (is_addr ? match : rx_on);
  wire store = rx_v & keep;
  // [RULE_12] [RULE_14] automatic enable and disable
  wire auto_en = rx_v & md & sdet & is_addr & match;
  wire auto_dis = rx_v & md & sdet & is_addr & ~match;
  wire ls_evt = rx_v & md & is_addr & (~sdet | match);
  // Outside multidrop the ninth bit is a parity error only when the
  // format forces parity to zero; otherwise it is ignored
  wire par_force0 = lfc[5:3] == rmd_pkg::PAR_FORCE0;
  wire perr_val = md ? is_addr : (par_force0 & is_addr);
  wire wr_txd = wr & hit_txd;
  wire rd_rxd = rd & hit_rxd;
  wire tx_done = tx_busy_q & ~tx_busy;
  // [RULE_07] [RULE_13] line status gated by enable
  wire [2:0] evts = {tx_done, ls_evt & interrupt_enable_reg[rmd_pkg::IER_LSI], store};
  wire [2:0] next_ist = (ist & ~(wr & hit_ist ? I_PWDATA[2:0] : 3'h0)) | evts;
  wire [7:0] efc_sw = wr & hit_efc ? (I_PWDATA[7:0] & rmd_pkg::EFC_MASK) : efc;
  // Hardware beats a software write in the same cycle, so an address
  // decision is never lost to a racing register update
  // [RULE_17] hardware acts on the software enable bit
  wire next_rxdis = auto_dis | (efc_sw[rmd_pkg::EFC_RXDIS] & ~auto_en);
  wire [7:0] next_efc = {efc_sw[7:2], next_rxdis, efc_sw[0]};
  // Pending covers the write cycle itself, so the driver turns round
  // before the start bit rather than during it
  wire pend = tx_hold_v | tx_busy | wr_txd;
  // [RULE_01] [RULE_15] auto direction overrides manual level
  wire next_rts_n = efc[rmd_pkg::EFC_TRANSMITTER_RTS_CONTROL] ? (efc[rmd_pkg::EFC_RTSINV] ? pend : ~pend)
    : ~rtm[0];

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      efc <= rmd_pkg::EFC_RST;
      enhanced_features_reg <= rmd_pkg::BYTE_RST;
      lfc <= rmd_pkg::BYTE_RST;
      interrupt_enable_reg <= rmd_pkg::BYTE_RST;
      xc2 <= rmd_pkg::BYTE_RST;
      rtm <= rmd_pkg::BYTE_RST;
      imk <= rmd_pkg::IST_RST;
    end else begin
      efc <= next_efc;
      if (wr & hit_efr) enhanced_features_reg <= I_PWDATA[7:0];
      if (wr & hit_lfc) lfc <= I_PWDATA[7:0];
      if (wr & hit_ier) interrupt_enable_reg <= I_PWDATA[7:0];
      if (wr & hit_xc2) xc2 <= I_PWDATA[7:0];
      if (wr & hit_rtm) rtm <= I_PWDATA[7:0];
      if (wr & hit_imk) imk <= I_PWDATA[2:0];
    end
  end

  // Receive holding register; a new character wins over a read
  // Overrun stays until line state is read, so a lost character is
  // visible to software even after the data register has been read
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      rx_data <= rmd_pkg::BYTE_RST;
      rx_dr <= 1'b0;
      rx_ovr <= 1'b0;
      rx_perr <= 1'b0;
    end else begin
      if (store) rx_data <= rx_word[7:0];
      if (store) rx_perr <= perr_val;
      rx_dr <= store | (rx_dr & ~rd_rxd);
      rx_ovr <= (store & rx_dr & ~rd_rxd) | (rx_ovr & ~(rd & hit_lst));
    end
  end

  // Transmit holding, status, interrupt and RTS pin
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      tx_hold <= 9'h000;
      tx_hold_v <= 1'b0;
      tx_busy_q <= 1'b0;
      ist <= rmd_pkg::IST_RST;
      O_IRQ <= 1'b0;
      O_RTS_N <= 1'b1;
    end else begin
      if (wr_txd & ~tx_hold_v) tx_hold <= I_PWDATA[8:0];
      tx_hold_v <= (tx_hold_v & ~tx_start) | wr_txd;
      tx_busy_q <= tx_busy;
      ist <= next_ist;
      O_IRQ <= |(next_ist & imk);
      O_RTS_N <= next_rts_n;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  rts_invert_a: assert property ( // [RULE_01]
    (efc[4] & efc[5] & tx_busy) |=> O_RTS_N) else $error("inverted RTS not high");
  rts_auto_a: assert property ( // [RULE_15]
    (efc[4] & ~efc[5] & wr_txd) |=> !O_RTS_N [*2]) else $error("RTS not low after write");
  md_off_a: assert property ( // [RULE_02]
    (rx_v & ~md) |=> !ist[1] || $past(ist[1])) else $error("address event in normal mode");
  addr_store_a: assert property ( // [RULE_06]
    (rx_v & md & ~sdet & is_addr) |=> rx_dr && rx_perr && ist[0]) else $error("address lost");
  data_drop_a: assert property ( // [RULE_03]
    (rx_v & md & ~is_addr & ~rx_on) |=> $stable(rx_data)) else $error("data stored while off");
  ls_irq_a: assert property ( // [RULE_07]
    (rx_v & md & ~sdet & is_addr & interrupt_enable_reg[2]) |=> ist[1]) else $error("no line status event");
  rx_keep_a: assert property ( // [RULE_09]
    (rx_v & md & ~sdet & rx_on) |=> rx_dr && rx_perr == $past(is_addr)) else $error("char lost");
  // [RULE_10] [RULE_13] [RULE_17]
  auto_enable_a: assert property ( // [RULE_12]
    auto_en |=> !efc[1] && rx_perr && rx_data == $past(xc2)) else $error("match not taken");
  auto_disable_a: assert property ( // [RULE_14]
    (auto_dis & rx_on) |=> efc[1] && $stable(rx_data)) else $error("foreign addr accepted");
  auto_drop_a: assert property ( // [RULE_11]
    (rx_v & md & sdet & ~is_addr & ~rx_on) |=> $stable(rx_data)) else $error("auto drop failed");
  rx_disable_a: assert property ( // [RULE_16]
    (rx_v & ~md & ~rx_on & ~rx_dr) |=> !rx_dr) else $error("disabled receiver stored");

  // ----------------------------------------
  // Bus, status, interrupt, transmit holding and RTS checks
  // ----------------------------------------
  // Ready lasts one cycle; a request held past it is taken again two cycles later
  ready_pulse_a: assert property (
    O_PREADY |=> !O_PREADY) else $error("ready longer than one cycle");
  // Error response only ever rides on the ready pulse
  slverr_ready_a: assert property (
    O_PSLVERR |-> O_PREADY) else $error("error without ready");
  // Ready comes exactly one cycle after the access phase opens
  ready_wait_a: assert property (
    (acc & ~O_PREADY) |=> O_PREADY) else $error("ready not after one wait");
  // A status bit stays set until software writes a one to it
  ist_sticky_a: assert property (
    (ist[0] & ~(wr & hit_ist & I_PWDATA[0])) |=> ist[0]) else $error("status bit lost");
  // Interrupt pin is the masked status while the mask holds still
  irq_level_a: assert property ( // [RULE_07]
    $stable(imk) |-> O_IRQ == |(ist & imk)) else $error("irq not masked status");
  // A write into a full holding register is dropped, not merged
  tx_full_drop_a: assert property (
    (wr_txd & tx_hold_v) |=> $stable(tx_hold)) else $error("full holding overwritten");
  // Manual level applies whenever the transmitter does not own the pin
  rts_manual_a: assert property ( // [RULE_15]
    ~efc[4] |=> O_RTS_N == ~$past(rtm[0])) else $error("manual RTS level wrong");

  addr_seen_c: cover property (ls_evt ##1 ist[1]);
  auto_en_c: cover property (auto_en ##[1:1000] auto_dis);
  tx_frame_c: cover property (wr_txd ##[1:300] tx_busy);
  rts_inv_c: cover property (efc[5] & efc[4] & tx_busy);
  auto_drop_c: cover property (auto_dis & ~rx_on);
endmodule

// *** src/rmd_tx.sv ***
// Purpose: Serial transmitter for start, eight data bits, parity bit, stop
// Assumes: i_start only while o_busy is low
// Notes: o_busy stays high until the stop bit has fully left
module rmd_tx #(
  parameter int BIT_CYC = rmd_pkg::BIT_CYC,
  parameter int NBITS = rmd_pkg::FRAME_BITS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [NBITS-1:0] i_data,
  output logic o_txd,
  output logic o_busy
);
  localparam int CW = $clog2(BIT_CYC);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
  localparam logic [3:0] LAST = 4'(NBITS - 1);

  rmd_pkg::rmd_state_t st;
  logic [CW-1:0] cnt;
  logic [3:0] idx;
  logic [NBITS-1:0] sh;
  wire tick = (cnt == '0);

  // ----------------------------------------
  // Frame shifter, LSB first
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st <= rmd_pkg::RMD_IDLE;
      cnt <= '0;
      idx <= 4'h0;
      sh <= '0;
      o_txd <= 1'b1;
      o_busy <= 1'b0;
    end else begin
      if (!tick) cnt <= cnt - 1'b1;
      unique case (st)
        rmd_pkg::RMD_IDLE: begin
          if (i_start) begin
            st <= rmd_pkg::RMD_START;
            sh <= i_data;
            cnt <= FULL;
            o_txd <= 1'b0;
            o_busy <= 1'b1;
          end
        end
        rmd_pkg::RMD_START: begin
          if (tick) begin
            st <= rmd_pkg::RMD_DATA;
            o_txd <= sh[0];
            sh <= sh >> 1;
            idx <= 4'h0;
            cnt <= FULL;
          end
        end
        rmd_pkg::RMD_DATA: begin
          if (tick) begin
            cnt <= FULL;
            if (idx == LAST) begin
              st <= rmd_pkg::RMD_STOP;
              o_txd <= 1'b1;
            end else begin
              o_txd <= sh[0];
              sh <= sh >> 1;
              idx <= idx + 4'h1;
            end
          end
        end
        rmd_pkg::RMD_STOP: begin
          if (tick) begin
            st <= rmd_pkg::RMD_IDLE;
            o_busy <= 1'b0;
          end
        end
      endcase
    end
  end

  tx_idle_mark_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_busy |-> o_txd) else $error("tx line low while idle");
endmodule

// *** verif/rmd_station.sv ***
// Purpose: Remote RS-485 master station model on the shared serial line
// Assumes: Same bit time as the block under test, one start and one stop bit
// Notes: Line idles high between frames, as the biased bus would
module rmd_station #(
  parameter int BIT_CYC = 8
) (
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic [8:0] i_frame,
  output logic o_rxd,
  output logic o_busy,
  input wire logic i_txd,
  output logic [9:0] o_frame,
  output logic [7:0] o_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] sh;
  logic [9:0] rb;

  initial begin
    o_rxd = 1'b1;
    o_busy = 1'b0;
    o_frame = 10'h000;
    o_count = 8'h00;
  end

  // Send start, eight data bits LSB first, address bit, stop
  always begin
    @(posedge i_clk);
    if (i_send) begin
      o_busy <= 1'b1;
      sh = {1'b1, i_frame, 1'b0};
      for (int k = 0; k < 11; k++) begin
        o_rxd <= sh[k];
        repeat (BIT_CYC) @(posedge i_clk);
      end
      o_busy <= 1'b0;
    end
  end

  // Capture frames sent by the block at mid-bit, stop bit included
  always begin
    @(negedge i_txd);
    repeat (BIT_CYC / 2) @(posedge i_clk);
    for (int k = 0; k < 10; k++) begin
      repeat (BIT_CYC) @(posedge i_clk);
      rb[k] = i_txd;
    end
    o_frame <= rb;
    o_count <= o_count + 8'h01;
  end
endmodule

// *** verif/test_rmd_top.sv ***
// Purpose: Self-checking bench for the RS-485 multidrop block
// Assumes: Short bit time of 8 clocks, APB master driven at rising edges
// Notes: Each scenario task drives the block and judges the result itself
module test_rmd_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BC = 8;
  logic clk, rstn, psel, penable, pwrite, send, txd, rts_n, irq, pready, pslverr, rxd, sbusy;
  logic [7:0] paddr, cnt;
  logic [31:0] pwdata, prdata;
  logic [8:0] sframe;
  logic [9:0] gframe;
  int err_total = 0;
  int tests_run = 0;

  rmd_top #(.BIT_CYC(BC)) dut (.I_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RXD(rxd),
    .O_TXD(txd), .O_RTS_N(rts_n), .O_IRQ(irq));
  rmd_station #(.BIT_CYC(BC)) peer (.i_clk(clk), .i_send(send), .i_frame(sframe),
    .o_rxd(rxd), .o_busy(sbusy), .i_txd(txd), .o_frame(gframe), .o_count(cnt));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic summarize();
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, ex, q);
  endtask

  // Wait for a condition count-limited; overrun ends the run
  task automatic idle_wait(input int lim);
    int n;
    n = 0;
    while (sbusy !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      summarize();
    end
  endtask

  // Station sends one character; block keeps or drops it
  task automatic rx_char(input logic [8:0] f, input logic keep, input logic irq_ex);
    logic [31:0] q;
    logic e;
    @(posedge clk);
    sframe <= f;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    idle_wait(200);
    repeat (8) @(posedge clk);
    apb(1'b0, rmd_pkg::OFF_LST, 32'h0, q, e);
    if (keep) begin
      chk("line state", {29'h0, f[8], 2'b01}, q);
      rd("rx data", rmd_pkg::OFF_RXD, {24'h0, f[7:0]});
    end else begin
      chk("data ready", 32'h0, {31'h0, q[0]});
    end
    chk("irq", {31'h0, irq_ex}, {31'h0, irq});
    wr(rmd_pkg::OFF_IST, 32'h7);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    chk("rts idle", 32'h1, {31'h0, rts_n});
    chk("txd idle", 32'h1, {31'h0, txd});
    rd("efc reset", rmd_pkg::OFF_EFC, 32'h0);
    rd("ier reset", rmd_pkg::OFF_IER, 32'h0);
    rd("ist reset", rmd_pkg::OFF_IST, 32'h0);
    wr(rmd_pkg::OFF_XC2, 32'hFFFFFFFF);
    rd("xc2 width", rmd_pkg::OFF_XC2, 32'hFF);
    wr(rmd_pkg::OFF_EFC, 32'hFF);
    rd("efc mask", rmd_pkg::OFF_EFC, {24'h0, rmd_pkg::EFC_MASK});
    wr(rmd_pkg::OFF_EFC, 32'h0);
    apb(1'b0, 8'h3C, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask

  task automatic t_rts(input logic inv);
    logic [7:0] c0;
    logic [8:0] f;
    f = inv ? 9'h05A : 9'h1A5;
    c0 = cnt;
    wr(rmd_pkg::OFF_EFC, {26'h0, inv, 5'h10});
    repeat (2) @(posedge clk);
    chk("rts rx side", {31'h0, ~inv}, {31'h0, rts_n});
    wr(rmd_pkg::OFF_TXD, {23'h0, f});
    repeat (3) @(posedge clk);
    chk("rts tx side", {31'h0, inv}, {31'h0, rts_n});
    for (int n = 0; n < 200 && cnt == c0; n++) @(posedge clk);
    chk("wire frame", {22'h0, 1'b1, f}, {22'h0, gframe});
    repeat (BC) @(posedge clk);
    chk("rts released", {31'h0, ~inv}, {31'h0, rts_n});
    rd("tx done", rmd_pkg::OFF_IST, 32'h4);
    wr(rmd_pkg::OFF_IMK, 32'h4);
    rd("mask", rmd_pkg::OFF_IMK, 32'h4);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(rmd_pkg::OFF_IST, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(rmd_pkg::OFF_IMK, 32'h2);
  endtask

  task automatic t_normal();
    wr(rmd_pkg::OFF_LFC, {26'h0, rmd_pkg::PAR_FORCE0, 3'h0});
    wr(rmd_pkg::OFF_IER, 32'h4);
    wr(rmd_pkg::OFF_IMK, 32'h2);
    rx_char(9'h155, 1'b1, 1'b0);
    wr(rmd_pkg::OFF_EFC, 32'h3);
    rx_char(9'h055, 1'b0, 1'b0);
    rx_char(9'h1A3, 1'b1, 1'b1);
    wr(rmd_pkg::OFF_EFC, 32'h1);
    rx_char(9'h042, 1'b1, 1'b0);
    rx_char(9'h1B0, 1'b1, 1'b1);
    wr(rmd_pkg::OFF_EFC, 32'h3);
    rx_char(9'h024, 1'b0, 1'b0);
    wr(rmd_pkg::OFF_EFC, 32'h2);
    rx_char(9'h042, 1'b0, 1'b0);
    wr(rmd_pkg::OFF_EFC, 32'h3);
  endtask

  task automatic t_auto();
    wr(rmd_pkg::OFF_EFR, 32'h20);
    wr(rmd_pkg::OFF_XC2, 32'h5A);
    rx_char(9'h011, 1'b0, 1'b0);
    rx_char(9'h15B, 1'b0, 1'b0);
    rd("still off", rmd_pkg::OFF_EFC, 32'h3);
    rx_char(9'h15A, 1'b1, 1'b1);
    rd("auto on", rmd_pkg::OFF_EFC, 32'h1);
    rx_char(9'h033, 1'b1, 1'b0);
    rx_char(9'h1DA, 1'b0, 1'b0);
    rd("auto off", rmd_pkg::OFF_EFC, 32'h3);
  endtask

  // ----------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    send = 1'b0;
    sframe = 9'h000;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_rts(1'b0);
    t_rts(1'b1);
    t_normal();
    t_auto();
    summarize();
  end
endmodule
